// >>> hdl/cfpc_pkg.sv
package cfpc_pkg;

	// System clock rate and the derived one-second tick.
	localparam int unsigned SYS_CLK_HZ     = 125000000;
	localparam int unsigned TICK_DIV       = SYS_CLK_HZ;

	// Interval lengths, in the unit of their name; FAN_DELAY_MS10 counts 100 ms steps.
	localparam int unsigned JUDGE_SEC      = 20;
	localparam int unsigned FORCED_RUN_SEC = 60;
	localparam int unsigned COOL_REST_MIN  = 3;
	localparam int unsigned DRY_REST_MIN   = 6;
	localparam int unsigned USER_REST_MIN  = 3;
	localparam int unsigned TIME_SAVE_MIN  = 7;
	localparam int unsigned FREEZE_MIN     = 4;
	localparam int unsigned REV_RUN_MIN    = 5;
	localparam int unsigned REV_DT_MIN     = 2;
	localparam int unsigned DRY_FIRST_MIN  = 10;
	localparam int unsigned DEW_MIN        = 30;
	localparam int unsigned DEW_BOOST_MIN  = 30;
	localparam int unsigned QLO_STEP1_MIN  = 60;
	localparam int unsigned QLO_STEP2_MIN  = 90;
	localparam int unsigned FAN_UP_SEC     = 70;
	localparam int unsigned FAN_TAIL_SEC   = 20;
	localparam int unsigned FAN_DELAY_MS10 = 16;

	// Interval lengths in ticks of the one-second enable.
	localparam int unsigned COOL_REST_S    = COOL_REST_MIN * 60;
	localparam int unsigned DRY_REST_S     = DRY_REST_MIN * 60;
	localparam int unsigned USER_REST_S    = USER_REST_MIN * 60;
	localparam int unsigned TIME_SAVE_S    = TIME_SAVE_MIN * 60;
	localparam int unsigned FREEZE_S       = FREEZE_MIN * 60;
	localparam int unsigned REV_RUN_S      = REV_RUN_MIN * 60;
	localparam int unsigned REV_DT_S       = REV_DT_MIN * 60;
	localparam int unsigned DRY_FIRST_S    = DRY_FIRST_MIN * 60;
	localparam int unsigned DEW_S          = DEW_MIN * 60;
	localparam int unsigned DEW_BOOST_S    = DEW_BOOST_MIN * 60;
	localparam int unsigned QLO_STEP1_S    = QLO_STEP1_MIN * 60;
	localparam int unsigned QLO_STEP2_S    = QLO_STEP2_MIN * 60;

	// Indoor fan start delay in system clocks (1.6 s).
	localparam int unsigned FAN_DELAY_CYC  = (SYS_CLK_HZ / 10) * FAN_DELAY_MS10;

	// Temperatures in half degrees Celsius, unsigned 8 bit.
	localparam logic [7:0] COOL_STD_T      = 8'h32;
	localparam logic [7:0] DRY_STD_T       = 8'h2C;
	localparam logic [7:0] STEP_T          = 8'h04;
	localparam logic [7:0] JUMPER_T        = 8'h04;
	localparam logic [7:0] JUDGE_T         = 8'h2E;
	localparam logic [7:0] FREEZE_T        = 8'h04;
	localparam logic [7:0] RECOVER_T       = 8'h14;
	localparam logic [7:0] REV_DT_T        = 8'h05;
	localparam logic [7:0] DEW_SET_T       = 8'h32;
	localparam logic [7:0] DEW_BAND_T      = 8'h02;
	localparam logic [7:0] HYST_T          = 8'h02;

	// Fan speed targets in rpm.
	localparam logic [11:0] RPM_SUPER_HIGH = 12'h6E0;
	localparam logic [11:0] RPM_HIGH       = 12'h69A;
	localparam logic [11:0] RPM_MEDIUM     = 12'h62C;
	localparam logic [11:0] RPM_LOW_PLUS   = 12'h5DC;
	localparam logic [11:0] RPM_LOW        = 12'h582;
	localparam logic [11:0] RPM_LOW_MINUS  = 12'h4B0;
	localparam logic [11:0] RPM_LOWEST     = 12'h3C0;
	localparam logic [11:0] RPM_QUIET_HIGH = 12'h636;
	localparam logic [11:0] RPM_QUIET_MED  = 12'h5C8;
	localparam logic [11:0] RPM_QUIET_LOW  = 12'h51E;
	localparam logic [11:0] RPM_QLO_STEP1  = 12'h064;
	localparam logic [11:0] RPM_QLO_STEP2  = 12'h0B4;

	// Airflow ranges in degrees.
	localparam logic [5:0] LOUVER_MIN      = 6'h0A;
	localparam logic [5:0] LOUVER_MAX      = 6'h26;
	localparam logic [5:0] LOUVER_DEW_MAX  = 6'h1B;
	localparam logic [5:0] VANE_MIN        = 6'h00;
	localparam logic [5:0] VANE_MAX        = 6'h2C;
	localparam logic [5:0] VANE_DEW_MIN    = 6'h0E;
	localparam logic [5:0] VANE_DEW_MAX    = 6'h1E;

	// User fan speed selection codes.
	localparam logic [2:0] FAN_SEL_AUTO    = 3'h0;
	localparam logic [2:0] FAN_SEL_LOW     = 3'h1;
	localparam logic [2:0] FAN_SEL_MEDIUM  = 3'h2;
	localparam logic [2:0] FAN_SEL_HIGH    = 3'h3;
	localparam logic [2:0] FAN_SEL_QLOW    = 3'h4;
	localparam logic [2:0] FAN_SEL_QMED    = 3'h5;
	localparam logic [2:0] FAN_SEL_QHIGH   = 3'h6;

	// User operating mode codes.
	localparam logic [1:0] MODE_COOL       = 2'h0;
	localparam logic [1:0] MODE_DRY        = 2'h1;
	localparam logic [1:0] MODE_AUTO       = 2'h2;

	// Operating state of the controller.
	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_JUDGE = 5'b00010,
		ST_COOL  = 5'b00100,
		ST_DRY   = 5'b01000,
		ST_SPARE = 5'b10000
	} cfpc_state_t;

endpackage : cfpc_pkg

// >>> hdl/cfpc_tick.sv
`timescale 1ns/1ps
`default_nettype none

// Divides the system clock into a one-cycle pulse every DIV cycles.
module cfpc_tick #(
	parameter int unsigned DIV = cfpc_pkg::TICK_DIV
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Enable pulse
	output logic      tick
);

	logic [31:0] count;

	// Free-running divider, wrapping at DIV.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			count <= 32'h0;
			tick  <= 1'b0;
		end
		else if (count >= DIV - 1)
		begin
			count <= 32'h0;
			tick  <= 1'b1;
		end
		else
		begin
			count <= count + 32'h1;
			tick  <= 1'b0;
		end
	end

endmodule : cfpc_tick

`default_nettype wire

// >>> hdl/cfpc_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Saturating seconds counter: counts ticks while run is high, clears otherwise.
module cfpc_timer #(
	parameter int unsigned W = 14
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset,
	// Control
	input  wire logic         tick,
	input  wire logic         run,
	// Elapsed seconds
	output logic [W-1:0]      secs
);

	// Counter restarts whenever its qualifying condition lapses.
	always_ff @(posedge sys_clk)
	begin
		if (reset || !run)
			secs <= '0;
		else if (tick && secs != {W{1'b1}})
			secs <= secs + W'(1);
	end

endmodule : cfpc_timer

`default_nettype wire

// >>> hdl/cfpc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Auto entry runs fan at lowest speed 20 s, then judges mode from intake.
// - Auto keeps the judged mode until off; standard setpoints 25 and 22 C.
// - User may shift the auto setpoint by one 2 C step up or down.
// - Open offset jumper raises judge temperature and standard setpoints by 2 C.
// - Thermostat-off in cooling keeps the compressor off at least 3 minutes.
// - Thermostat-off in dehumidifying keeps the compressor off at least 6 minutes.
// - After user stop the compressor stays off 3 minutes even if restarted.
// - Stopped 7 minutes with intake inside the band starts the compressor.
// - Compressor runs at least 60 s after start; only user off or the freeze latch stops it.
// - Exchanger below 2 C for 4 minutes stops compressor; fan setting kept.
// - After freeze stop, restart at 10 C, still obeying restart delay.
// - After 5 minutes run, small delta for 2 minutes stops then restarts.
// - Indoor fan starts 1.6 s after the compressor only when auto fan has it off at the start.
// - Dew mode after 30 stable minutes with listed conditions; cancels at once.
// - Dew mode at low speed switches to low-plus after 30 minutes.
// - Dew mode quiet-low steps +100 rpm after 1 h, +180 rpm after 90 min.
// - Dew mode narrows louver to 10-27 deg, manual 10/13/16/19/22.
// - Dew mode narrows vane to 14-30 deg, manual 14/18/22/26/30.
// - Fan speed targets use the listed rpm for each named speed.
// - Auto fan cooling: high 70 s after first start, medium after restarts.
// - Auto fan cooling off: low-minus 20 s, then off, resume after 3 minutes.
// - Auto fan dry alternates off and low-minus, resumes after 6 minutes off.
// - Dry mode first run at most 10 minutes, then off at least 6 minutes.
module cfpc_ctrl #(
	parameter int unsigned TICK_DIV  = cfpc_pkg::TICK_DIV,
	parameter int unsigned FAN_DELAY = cfpc_pkg::FAN_DELAY_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// User settings
	input  wire logic        powerOn,
	input  wire logic [1:0]  modeSel,
	input  wire logic [7:0]  userSetpoint,
	input  wire logic [1:0]  autoShift,
	input  wire logic [2:0]  fanSel,
	input  wire logic        louverAuto,
	input  wire logic [2:0]  louverPos,
	input  wire logic        vaneAuto,
	input  wire logic [2:0]  vanePos,
	// Sensors and jumper (asynchronous)
	input  wire logic [7:0]  intakeTemp,
	input  wire logic [7:0]  coilTemp,
	input  wire logic        setpointOffsetJumperOpen,
	// Actuators
	output logic             compressorOn,
	output logic [11:0]      fanRpm,
	output logic [5:0]       louverLo,
	output logic [5:0]       louverHi,
	output logic [5:0]       vaneLo,
	output logic [5:0]       vaneHi,
	// Status
	output logic             dewActive,
	output logic             quietLed,
	output logic [7:0]       activeSetpoint,
	output logic [4:0]       opState
);

	cfpc_pkg::cfpc_state_t state;

	logic [7:0]  intakeMeta, intakeT, coilMeta, coilT;
	logic        jmpMeta, jmpSync, powerPrev;
	logic        tick, thermoReq, firstRun, restPending, userStop;
	logic        freezeLatch, revLatch, dryFirstDone, startedOnce;
	logic        fanHold, compPrev, dewOk, restarted;
	logic [7:0]  roomRef, judgeT, setpoint, jmpAdd;
	logic [13:0] offSecs, runSecs, judgeSecs, freezeSecs, revSecs, dewSecs, boostSecs, stopSecs;
	logic [13:0] restNeed;
	logic [31:0] fanDelay;
	logic        permit;

	// Two-stage synchronisers for sensor words and the jumper.
	always_ff @(posedge sys_clk)
	begin
		intakeMeta <= intakeTemp;
		intakeT    <= intakeMeta;
		coilMeta   <= coilTemp;
		coilT      <= coilMeta;
		jmpMeta    <= setpointOffsetJumperOpen;
		jmpSync    <= jmpMeta;
	end

	cfpc_tick #(.DIV(TICK_DIV)) u_tick (
		.sys_clk (sys_clk),
		.reset   (reset),
		.tick    (tick)
	);

	// Judge and setpoint arithmetic.
	assign jmpAdd = jmpSync ? cfpc_pkg::JUMPER_T : 8'h00;
	assign judgeT = cfpc_pkg::JUDGE_T + jmpAdd;
	always_comb
	begin
		setpoint = userSetpoint;
		if (modeSel == cfpc_pkg::MODE_AUTO)
		begin
			setpoint = ((state == cfpc_pkg::ST_DRY) ? cfpc_pkg::DRY_STD_T
				: cfpc_pkg::COOL_STD_T) + jmpAdd;
			if (autoShift == 2'h1)
				setpoint = setpoint + cfpc_pkg::STEP_T;
			else if (autoShift == 2'h2)
				setpoint = setpoint - cfpc_pkg::STEP_T;
		end
	end

	// Operating state: off, auto judgement, cooling, dehumidifying.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			state <= cfpc_pkg::ST_OFF;
		else
		begin
			case (state)
				cfpc_pkg::ST_OFF:
					if (powerOn)
						state <= (modeSel == cfpc_pkg::MODE_AUTO) ? cfpc_pkg::ST_JUDGE
							: (modeSel == cfpc_pkg::MODE_DRY) ? cfpc_pkg::ST_DRY
							: cfpc_pkg::ST_COOL;
				cfpc_pkg::ST_JUDGE:
					if (!powerOn)
						state <= cfpc_pkg::ST_OFF;
					else if (judgeSecs >= 14'(cfpc_pkg::JUDGE_SEC))
						state <= (intakeT >= judgeT) ? cfpc_pkg::ST_COOL
							: cfpc_pkg::ST_DRY;
				cfpc_pkg::ST_COOL, cfpc_pkg::ST_DRY:
					if (!powerOn)
						state <= cfpc_pkg::ST_OFF;
				default:
					state <= cfpc_pkg::ST_OFF;
			endcase
		end
	end

	cfpc_timer u_judge (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(state == cfpc_pkg::ST_JUDGE), .secs(judgeSecs));
	cfpc_timer u_off (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(!compressorOn), .secs(offSecs));
	cfpc_timer u_run (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(compressorOn), .secs(runSecs));
	cfpc_timer u_frz (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(coilT < cfpc_pkg::FREEZE_T), .secs(freezeSecs));
	cfpc_timer u_rev (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(compressorOn && runSecs >= 14'(cfpc_pkg::REV_RUN_S)
			&& intakeT <= coilT + cfpc_pkg::REV_DT_T), .secs(revSecs));
	cfpc_timer u_dew (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(dewOk), .secs(dewSecs));
	cfpc_timer u_boost (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(dewActive), .secs(boostSecs));
	cfpc_timer u_stop (.sys_clk(sys_clk), .reset(reset), .tick(tick),
		.run(!powerOn), .secs(stopSecs));

	// Thermostat demand with hysteresis around the active setpoint.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			thermoReq <= 1'b0;
		else if (intakeT >= setpoint + cfpc_pkg::HYST_T)
			thermoReq <= 1'b1;
		else if (intakeT + cfpc_pkg::HYST_T <= setpoint)
			thermoReq <= 1'b0;
	end

	// Protection latches: freeze, reverse rotation and the dry first cycle.
	always_ff @(posedge sys_clk)
	begin
		if (reset || state == cfpc_pkg::ST_OFF)
		begin
			freezeLatch  <= 1'b0;
			revLatch     <= 1'b0;
			dryFirstDone <= 1'b0;
		end
		else
		begin
			if (freezeSecs >= 14'(cfpc_pkg::FREEZE_S))
				freezeLatch <= 1'b1;
			else if (coilT >= cfpc_pkg::RECOVER_T)
				freezeLatch <= 1'b0;
			if (revSecs >= 14'(cfpc_pkg::REV_DT_S))
				revLatch <= 1'b1;
			else if (!compressorOn)
				revLatch <= 1'b0;
			if (state == cfpc_pkg::ST_DRY && runSecs >= 14'(cfpc_pkg::DRY_FIRST_S))
				dryFirstDone <= 1'b1;
		end
	end

	// Remembers a user stop so the restart wait covers it.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			powerPrev <= 1'b0;
			userStop  <= 1'b0;
		end
		else
		begin
			powerPrev <= powerOn;
			if (powerPrev && !powerOn)
				userStop <= 1'b1;
			else if (stopSecs >= 14'(cfpc_pkg::USER_REST_S) || offSecs >= 14'(cfpc_pkg::USER_REST_S))
				userStop <= 1'b0;
		end
	end

	// Minimum off time depends on the mode that stopped the compressor.
	assign restNeed = (state == cfpc_pkg::ST_DRY) ? 14'(cfpc_pkg::DRY_REST_S)
		: 14'(cfpc_pkg::COOL_REST_S);
	assign firstRun = !startedOnce;

	// Compressor permission: every protection must agree.
	always_comb
	begin
		permit = (state == cfpc_pkg::ST_COOL || state == cfpc_pkg::ST_DRY)
			&& !freezeLatch && !revLatch
			&& !userStop
			&& (firstRun || offSecs >= restNeed)
			&& (thermoReq || offSecs >= 14'(cfpc_pkg::TIME_SAVE_S));
	end

	// Compressor output and start bookkeeping.
	always_ff @(posedge sys_clk)
	begin
		if (reset || !powerOn)
		begin
			compressorOn <= 1'b0;
			startedOnce  <= 1'b0;
			restarted    <= 1'b0;
		end
		else if (compressorOn)
		begin
			if (freezeLatch || revLatch)
				compressorOn <= 1'b0;
			else if (state == cfpc_pkg::ST_DRY && !dryFirstDone
				&& runSecs >= 14'(cfpc_pkg::DRY_FIRST_S))
				compressorOn <= 1'b0;
			else if (!thermoReq && runSecs >= 14'(cfpc_pkg::FORCED_RUN_SEC)
				&& (state != cfpc_pkg::ST_DRY || dryFirstDone))
				compressorOn <= 1'b0;
		end
		else if (permit && (state != cfpc_pkg::ST_DRY || !dryFirstDone
			|| offSecs >= 14'(cfpc_pkg::DRY_REST_S)))
		begin
			compressorOn <= 1'b1;
			startedOnce  <= 1'b1;
			restarted    <= startedOnce;
		end
	end

	// Indoor fan start stagger when the fan speed chosen on the compressor's starting edge is zero.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			compPrev <= 1'b0;
			fanDelay <= 32'h0;
			fanHold  <= 1'b0;
		end
		else
		begin
			compPrev <= compressorOn;
			if (compressorOn && !compPrev && fanRpm == 12'h000)
			begin
				fanHold  <= 1'b1;
				fanDelay <= 32'h0;
			end
			else if (fanHold)
			begin
				fanDelay <= fanDelay + 32'h1;
				if (fanDelay >= FAN_DELAY - 1)
					fanHold <= 1'b0;
			end
		end
	end

	// Dew prevention qualification.
	assign dewOk = state == cfpc_pkg::ST_COOL && compressorOn
		&& setpoint < cfpc_pkg::DEW_SET_T
		&& (fanSel == cfpc_pkg::FAN_SEL_LOW || fanSel == cfpc_pkg::FAN_SEL_QLOW)
		&& intakeT <= roomRef + cfpc_pkg::DEW_BAND_T
		&& intakeT + cfpc_pkg::DEW_BAND_T >= roomRef;

	// Room reference and dew activation; any lapse cancels immediately.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			roomRef   <= 8'h00;
			dewActive <= 1'b0;
		end
		else
		begin
			if (!dewOk)
				roomRef <= intakeT;
			dewActive <= dewOk && dewSecs >= 14'(cfpc_pkg::DEW_S);
		end
	end

	// Fan speed selection.
	always_ff @(posedge sys_clk)
	begin
		if (reset || state == cfpc_pkg::ST_OFF)
			fanRpm <= 12'h000;
		else if (state == cfpc_pkg::ST_JUDGE)
			fanRpm <= cfpc_pkg::RPM_LOWEST;
		else if (fanHold || (compressorOn && !compPrev && fanRpm == 12'h000))
			fanRpm <= 12'h000;
		else
		begin
			case (fanSel)
				cfpc_pkg::FAN_SEL_LOW:
					fanRpm <= (dewActive && boostSecs >= 14'(cfpc_pkg::DEW_BOOST_S))
						? cfpc_pkg::RPM_LOW_PLUS : cfpc_pkg::RPM_LOW;
				cfpc_pkg::FAN_SEL_MEDIUM: fanRpm <= cfpc_pkg::RPM_MEDIUM;
				cfpc_pkg::FAN_SEL_HIGH:   fanRpm <= cfpc_pkg::RPM_HIGH;
				cfpc_pkg::FAN_SEL_QHIGH:  fanRpm <= cfpc_pkg::RPM_QUIET_HIGH;
				cfpc_pkg::FAN_SEL_QMED:   fanRpm <= cfpc_pkg::RPM_QUIET_MED;
				cfpc_pkg::FAN_SEL_QLOW:
					if (dewActive && boostSecs >= 14'(cfpc_pkg::QLO_STEP2_S))
						fanRpm <= cfpc_pkg::RPM_QUIET_LOW + cfpc_pkg::RPM_QLO_STEP2;
					else if (dewActive && boostSecs >= 14'(cfpc_pkg::QLO_STEP1_S))
						fanRpm <= cfpc_pkg::RPM_QUIET_LOW + cfpc_pkg::RPM_QLO_STEP1;
					else
						fanRpm <= cfpc_pkg::RPM_QUIET_LOW;
				default:
					if (compressorOn)
						fanRpm <= (runSecs < 14'(cfpc_pkg::FAN_UP_SEC) || state == cfpc_pkg::ST_DRY)
							? cfpc_pkg::RPM_LOW_MINUS
							: !restarted
							? cfpc_pkg::RPM_HIGH : cfpc_pkg::RPM_MEDIUM;
					else if (state == cfpc_pkg::ST_DRY)
						fanRpm <= (offSecs >= 14'(cfpc_pkg::DRY_REST_S))
							? cfpc_pkg::RPM_LOW_MINUS : 12'h000;
					else
						fanRpm <= (offSecs < 14'(cfpc_pkg::FAN_TAIL_SEC)
							|| offSecs >= 14'(cfpc_pkg::COOL_REST_S))
							? cfpc_pkg::RPM_LOW_MINUS : 12'h000;
			endcase
		end
	end

	// Louver and vane ranges; manual selects one point of five.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			louverLo <= cfpc_pkg::LOUVER_MIN;
			louverHi <= cfpc_pkg::LOUVER_MAX;
			vaneLo   <= cfpc_pkg::VANE_MIN;
			vaneHi   <= cfpc_pkg::VANE_MAX;
		end
		else
		begin
			louverLo <= louverAuto ? cfpc_pkg::LOUVER_MIN
				: dewActive ? 6'(10 + 3 * louverPos) : 6'(10 + 4 * louverPos + (louverPos == 3'h4));
			louverHi <= louverAuto ? (dewActive ? cfpc_pkg::LOUVER_DEW_MAX : cfpc_pkg::LOUVER_MAX)
				: dewActive ? 6'(10 + 3 * louverPos) : 6'(10 + 4 * louverPos + (louverPos == 3'h4));
			vaneLo   <= vaneAuto ? (dewActive ? cfpc_pkg::VANE_DEW_MIN : cfpc_pkg::VANE_MIN)
				: dewActive ? 6'(14 + 4 * vanePos) : 6'(11 * vanePos);
			vaneHi   <= vaneAuto ? (dewActive ? cfpc_pkg::VANE_DEW_MAX : cfpc_pkg::VANE_MAX)
				: dewActive ? 6'(14 + 4 * vanePos) : 6'(11 * vanePos);
		end
	end

	// Status outputs.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			quietLed       <= 1'b0;
			activeSetpoint <= 8'h00;
			opState        <= 5'h01;
		end
		else
		begin
			quietLed       <= fanSel >= cfpc_pkg::FAN_SEL_QLOW && fanSel <= cfpc_pkg::FAN_SEL_QHIGH;
			activeSetpoint <= setpoint;
			opState        <= state;
		end
	end

endmodule : cfpc_ctrl

`default_nettype wire

// >>> tb/cfpc_props.sv
`timescale 1ns/1ps
`default_nettype none

// Timing and range checks at the controller ports.
module cfpc_props #(
	parameter int unsigned TICK_DIV = 10
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// Watched ports
	input wire logic        powerOn,
	input wire logic        compressorOn,
	input wire logic [11:0] fanRpm,
	input wire logic [5:0]  louverLo,
	input wire logic [5:0]  louverHi,
	input wire logic [5:0]  vaneLo,
	input wire logic [5:0]  vaneHi,
	input wire logic        dewActive,
	input wire logic [4:0]  opState
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [31:0] onCyc;
	logic [31:0] offCyc;
	logic [31:0] judgeCyc;

	// Cycles on, off and judging; off starts high so a first start is allowed.
	always_ff @(posedge sys_clk)
	begin
		onCyc    <= (reset || !compressorOn) ? 32'h0 : onCyc + 32'h1;
		offCyc   <= reset ? 32'hFFFF : (compressorOn ? 32'h0 : offCyc + 32'h1);
		judgeCyc <= (opState == 5'h02) ? judgeCyc + 32'h1 : 32'h0;
	end

	reset_idle_a: assert property (disable iff (1'b0)
		reset |=> !compressorOn && opState == 5'h01) else $error("not idle after reset");
	state_onehot_a: assert property ($onehot(opState)) else $error("state not one-hot");
	restart_wait_a: assert property ($rose(compressorOn)
		|-> offCyc >= (cfpc_pkg::USER_REST_S - 1) * TICK_DIV) else $error("restart too soon");
	min_run_a: assert property ($fell(compressorOn) && powerOn && $past(powerOn, 4)
		|-> onCyc >= (cfpc_pkg::FORCED_RUN_SEC - 1) * TICK_DIV) else $error("stopped too early");
	judge_len_a: assert property ($past(opState) == 5'h02 && opState != 5'h02 && powerOn
		|-> judgeCyc >= (cfpc_pkg::JUDGE_SEC - 1) * TICK_DIV) else $error("judge too short");
	judge_fan_a: assert property (opState == 5'h02 && $past(opState, 8) == 5'h02
		|-> fanRpm == cfpc_pkg::RPM_LOWEST) else $error("judge fan wrong");
	fan_delay_a: assert property ($rose(compressorOn) && fanRpm == 12'h000
		|=> (fanRpm == 12'h000) [*2]) else $error("fan started with compressor");
	dew_range_a: assert property (dewActive && $past(dewActive, 2)
		|-> louverLo >= 6'h0A && louverHi <= 6'h1B && vaneLo >= 6'h0E && vaneHi <= 6'h1E)
		else $error("dew ranges wide");
	dew_cancel_a: assert property ($fell(compressorOn) |-> ##[0:4] !dewActive)
		else $error("dew kept after stop");
endmodule : cfpc_props

bind cfpc_ctrl cfpc_props #(.TICK_DIV(TICK_DIV)) cfpc_props_i (.sys_clk(sys_clk), .reset(reset),
	.powerOn(powerOn), .compressorOn(compressorOn), .fanRpm(fanRpm), .louverLo(louverLo),
	.louverHi(louverHi), .vaneLo(vaneLo), .vaneHi(vaneHi), .dewActive(dewActive),
	.opState(opState));
`default_nettype wire

// >>> tb/cfpc_plant.sv
`timescale 1ns/1ps
`default_nettype none

// Room and coil sensors; the coil slews so protections see a real ramp.
module cfpc_plant (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Actuator and scenario controls
	input  wire logic       compressorOn,
	input  wire logic [7:0] roomSet,
	input  wire logic       freeze,
	// Sensor readings
	output logic      [7:0] intakeTemp,
	output logic      [7:0] coilTemp
);
	logic [7:0] target;
	logic       slow;

	// The coil sits 10 C under the room while cooling, near 1 C when iced.
	assign target = freeze ? 8'h02 : (compressorOn ? roomSet - 8'h14 : roomSet);
	assign intakeTemp = roomSet;

	// One half degree every second cycle.
	always_ff @(posedge sys_clk)
	begin
		slow <= !reset && !slow;
		if (reset)
			coilTemp <= roomSet;
		else if (slow && coilTemp != target)
			coilTemp <= (coilTemp < target) ? coilTemp + 8'h01 : coilTemp - 8'h01;
	end
endmodule : cfpc_plant
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the cooling supervisor.
module tb;
	localparam int unsigned DIV = 10;
	logic        sys_clk, reset, powerOn, louverAuto, vaneAuto, freeze;
	logic        setpointOffsetJumperOpen, compressorOn, dewActive, quietLed;
	logic [1:0]  modeSel, autoShift;
	logic [2:0]  fanSel, louverPos, vanePos;
	logic [7:0]  userSetpoint, roomSet, intakeTemp, coilTemp, activeSetpoint;
	logic [11:0] fanRpm;
	logic [5:0]  louverLo, louverHi, vaneLo, vaneHi;
	logic [4:0]  opState;
	logic [31:0] seed;
	int          errors, total_checks, n, t0;
	int          cycles = 0;

	cfpc_ctrl #(.TICK_DIV(DIV), .FAN_DELAY(4)) cfpc_ctrl_i (.sys_clk, .reset, .powerOn,
		.modeSel, .userSetpoint, .autoShift, .fanSel, .louverAuto, .louverPos, .vaneAuto,
		.vanePos, .intakeTemp, .coilTemp, .setpointOffsetJumperOpen, .compressorOn, .fanRpm,
		.louverLo, .louverHi, .vaneLo, .vaneHi, .dewActive, .quietLed, .activeSetpoint, .opState);
	cfpc_plant cfpc_plant_i (.sys_clk, .reset, .compressorOn, .roomSet, .freeze, .intakeTemp,
		.coilTemp);

	// Free-running 125 MHz clock.
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// A hang counts as a mismatch and ends the run.
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			errors++;
			print_verdict();
		end
	end

	// Bench helpers: random source, expectations, waits and comparison.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	function automatic logic [11:0] aim(input logic [2:0] p);
		case (p)
			3'h0: return {6'h0A, 6'h00};
			3'h1: return {6'h0E, 6'h0B};
			3'h2: return {6'h12, 6'h16};
			3'h3: return {6'h16, 6'h21};
			default: return {6'h1B, 6'h2C};
		endcase
	endfunction : aim
	function automatic logic [7:0] shifted(input logic [7:0] b, input logic [1:0] k);
		return (k == 2'h1) ? b + cfpc_pkg::STEP_T : ((k == 2'h2) ? b - cfpc_pkg::STEP_T : b);
	endfunction : shifted
	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic waitComp(input logic lvl, input int lim);
		n = 0;
		do
		begin
			step(1);
			n++;
		end
		while (compressorOn !== lvl && n < lim);
	endtask : waitComp
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// Main sequence: each stimulus change lands on a rising edge.
	initial
	begin
		errors = 0;
		total_checks = 0;
		seed = 32'h5C;
		reset = 1'b1;
		powerOn = 1'b0;
		modeSel = cfpc_pkg::MODE_AUTO;
		userSetpoint = 8'h2E;
		autoShift = 2'h0;
		fanSel = cfpc_pkg::FAN_SEL_AUTO;
		louverAuto = 1'b1;
		louverPos = 3'h0;
		vaneAuto = 1'b1;
		vanePos = 3'h0;
		roomSet = 8'h3C;
		freeze = 1'b0;
		setpointOffsetJumperOpen = 1'b0;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		step(1);
		check("resetComp", 0, compressorOn);
		check("resetRanges", 24'h2A602C, {louverLo, louverHi, vaneLo, vaneHi});
		$display("test reset done");
		@(posedge sys_clk) powerOn <= 1'b1;
		step(20);
		check("judgeFan", cfpc_pkg::RPM_LOWEST, fanRpm);
		step(cfpc_pkg::JUDGE_SEC * DIV + 20);
		check("autoMode", 5'h04, opState);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge sys_clk) autoShift <= k[1:0];
			step(4);
			check("autoSet", shifted(cfpc_pkg::COOL_STD_T, k[1:0]), activeSetpoint);
		end
		waitComp(1'b1, 400);
		step(cfpc_pkg::FAN_UP_SEC * DIV + 30);
		check("autoFanHigh", cfpc_pkg::RPM_HIGH, fanRpm);
		$display("test auto done");
		@(posedge sys_clk) powerOn <= 1'b0;
		step(8);
		@(posedge sys_clk);
		modeSel <= cfpc_pkg::MODE_COOL;
		fanSel <= cfpc_pkg::FAN_SEL_LOW;
		roomSet <= 8'h31;
		louverAuto <= 1'b0;
		vaneAuto <= 1'b0;
		powerOn <= 1'b1;
		waitComp(1'b1, 2200);
		check("userRest", 1, n + 9 >= (cfpc_pkg::USER_REST_S - 1) * DIV && n < 2200);
		t0 = cycles;
		repeat (4)
		begin
			seed = xs(seed);
			@(posedge sys_clk);
			louverPos <= 3'(seed % 5);
			vanePos <= 3'(seed % 5);
			step(4);
			check("manualAim", aim(3'(seed % 5)), {louverHi, vaneHi});
		end
		@(posedge sys_clk);
		louverAuto <= 1'b1;
		vaneAuto <= 1'b1;
		n = 0;
		while (dewActive !== 1'b1 && n < 20000)
		begin
			step(1);
			n++;
		end
		check("dewStart", 1, cycles - t0 >= (cfpc_pkg::DEW_S - 1) * DIV && n < 20000);
		step(4);
		check("dewRanges", 24'h29B39E, {louverLo, louverHi, vaneLo, vaneHi});
		check("dewLowFan", cfpc_pkg::RPM_LOW, fanRpm);
		step(cfpc_pkg::DEW_BOOST_S * DIV + 20);
		check("dewBoost", cfpc_pkg::RPM_LOW_PLUS, fanRpm);
		@(posedge sys_clk) fanSel <= cfpc_pkg::FAN_SEL_HIGH;
		step(6);
		check("dewCancel", 0, dewActive);
		$display("test dew done");
		@(posedge sys_clk) freeze <= 1'b1;
		waitComp(1'b0, 2600);
		check("freezeStop", 1, n >= (cfpc_pkg::FREEZE_S - 1) * DIV && n < 2600);
		check("freezeFan", cfpc_pkg::RPM_HIGH, fanRpm);
		@(posedge sys_clk) freeze <= 1'b0;
		waitComp(1'b1, 2400);
		check("freezeRestart", 1, n >= (cfpc_pkg::COOL_REST_S - 2) * DIV && n < 2400);
		$display("test freeze done");
		@(posedge sys_clk);
		powerOn <= 1'b0;
		setpointOffsetJumperOpen <= 1'b1;
		roomSet <= 8'h30;
		modeSel <= cfpc_pkg::MODE_AUTO;
		autoShift <= 2'h0;
		fanSel <= cfpc_pkg::FAN_SEL_QLOW;
		step(8);
		@(posedge sys_clk) powerOn <= 1'b1;
		step(cfpc_pkg::JUDGE_SEC * DIV + 40);
		check("jumperMode", 5'h08, opState);
		check("jumperSet", cfpc_pkg::DRY_STD_T + cfpc_pkg::JUMPER_T, activeSetpoint);
		check("quietFan", cfpc_pkg::RPM_QUIET_LOW, fanRpm);
		check("quietLed", 1, quietLed);
		$display("test jumper done");
		print_verdict();
	end
endmodule : tb
`default_nettype wire
